// ===== design/vid_telemetry_params.svh
/*
  Constants of the two-wire telemetry slave: bus address, register offsets,
  output-voltage code limits and reset values.
  Assumes it is included by bare name from the design module.
*/
`ifndef VID_TELEMETRY_PARAMS_SVH
`define VID_TELEMETRY_PARAMS_SVH

// fixed upper four address bits, binary 1000
`define ADDR_FIXED_HI     4'h8
// strapped low address bits per voltage band
`define ADDR_LSB_BAND0    3'h0
`define ADDR_LSB_BAND1    3'h3
`define ADDR_LSB_BAND2    3'h5
// high-speed master code is 0000_1xxx
`define HS_MASTER_CODE    5'h01
// register offsets
`define REG_VOLTAGE_CODE  8'h01
`define REG_LOAD_CURRENT  8'h03
`define REG_FAULT_STATUS  8'h14
// legal output-voltage codes and boot value
`define VCODE_MIN         7'h19
`define VCODE_MAX         7'h7F
`define VCODE_RESET       7'h4B
// bits in a byte
`define BYTE_BITS         4'h8
// cycles after reset release before the strap is caught
`define STRAP_SETTLE      2'h3

`endif

// ===== design/vid_telemetry_pkg.sv
/*
  Types of the two-wire telemetry slave.
  Assumes nothing of its surroundings.
*/
package vid_telemetry_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_REG   = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_ACK   = 3'b101,
    ST_WAIT  = 3'b110
  } link_state_e;

endpackage

// ===== design/vid_telemetry_i2c_slave.sv
/*
  Two-wire slave for output-voltage code control and load-current telemetry.
  Assumes scl_i, sda_i and the strap band arrive asynchronously and are
  oversampled by clock_i (20 MHz); telemetry and fault inputs are synchronous.
  sda is open drain: sda_o is always low, sda_oe_o pulls the line.
  High-speed mode is only flagged; scl must stay slow enough for the oversampling.
*/
// Overview of operation
// - answer only address 1000 plus strapped bits
// - catch strap bits once after reset
// - strap band maps to 000, 011, 101
// - single byte read or write only
// - ack address, register; return one byte
// - NAK unknown register byte on read
// - NAK unknown register write, change nothing
// - NAK and drop illegal write data
// - enter high-speed after master code
// - interface ignores regulator enable
// - writes set voltage code, reads telemetry
// - telemetry register returns 8-bit load current
// - voltage code is seven bits
// - fault status readable after protection fault
`timescale 1ns/1ps
`include "vid_telemetry_params.svh"

module vid_telemetry_i2c_slave
  import vid_telemetry_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // two-wire bus
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // strap band: 0 low, 1 middle, 2 high
  input  wire logic [1:0] address_slew_strap_pin_i,
  // telemetry and status
  input  wire logic [7:0] current_monitor_output_i,
  input  wire logic [7:0] fault_status_i,
  // controls
  output logic [6:0]      output_voltage_code_o,
  output logic            hs_mode_o
);

  logic [2:0]  scl_s;
  logic [2:0]  sda_s;
  logic [1:0]  strap_m;
  logic [1:0]  strap_s;
  logic [1:0]  strap_wait;
  logic        strap_done;
  logic [2:0]  addr_lsb;
  link_state_e state;
  link_state_e after_ack;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  reg_ptr;
  logic        ptr_ok;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic        ptr_known;
  logic        wdata_ok;
  logic [7:0]  read_value;

  // only stage 1 onward is looked at; stage 0 is the metastable catch
  assign scl_rise   = scl_s[1] & ~scl_s[2];
  assign scl_fall   = ~scl_s[1] & scl_s[2];
  assign start_seen = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_seen  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  // only the three listed offsets exist
  assign ptr_known = (shreg == `REG_VOLTAGE_CODE) || (shreg == `REG_LOAD_CURRENT)
                     || (shreg == `REG_FAULT_STATUS);
  // read-only targets and codes off the table are illegal data
  assign wdata_ok  = ptr_ok && (reg_ptr == `REG_VOLTAGE_CODE) && !shreg[7]
                     && (shreg[6:0] >= `VCODE_MIN) && (shreg[6:0] <= `VCODE_MAX);

  // an unknown pointer still reads back zero once the read address is acked
  always_comb begin
    read_value = 8'h00;
    if (reg_ptr == `REG_VOLTAGE_CODE) begin
      read_value = {1'b0, output_voltage_code_o};
    end else if (reg_ptr == `REG_LOAD_CURRENT) begin
      read_value = current_monitor_output_i;
    end else if (reg_ptr == `REG_FAULT_STATUS) begin
      read_value = fault_status_i;
    end
  end

  // reset to the idle high level so no false edge follows reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
    end
  end

  // strap is caught once, a few cycles after release, so the synchroniser has filled
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      strap_m    <= 2'h0;
      strap_s    <= 2'h0;
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
      addr_lsb   <= `ADDR_LSB_BAND0;
    end else begin
      strap_m <= address_slew_strap_pin_i;
      strap_s <= strap_m;
      if (!strap_done) begin
        if (strap_wait == `STRAP_SETTLE) begin
          strap_done <= 1'b1;
          case (strap_s)
            2'h1:    addr_lsb <= `ADDR_LSB_BAND1;
            2'h2:    addr_lsb <= `ADDR_LSB_BAND2;
            default: addr_lsb <= `ADDR_LSB_BAND0;
          endcase
        end else begin
          strap_wait <= strap_wait + 2'h1;
        end
      end
    end
  end

  // regulator enable is not an input at all, so the link runs regardless
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state                 <= ST_IDLE;
      after_ack             <= ST_WAIT;
      bit_cnt               <= 4'h0;
      shreg                 <= 8'h00;
      reg_ptr               <= 8'h00;
      ptr_ok                <= 1'b0;
      sda_o                 <= 1'b0;
      sda_oe_o              <= 1'b0;
      output_voltage_code_o <= `VCODE_RESET;
      hs_mode_o             <= 1'b0;
    end else if (stop_seen) begin
      // a stop ends any frame, even one cut short mid-byte
      state     <= ST_IDLE;
      sda_oe_o  <= 1'b0;
      hs_mode_o <= 1'b0;
    end else if (start_seen) begin
      // repeated start keeps the register pointer for the read phase
      state    <= ST_ADDR;
      bit_cnt  <= 4'h0;
      sda_oe_o <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise && bit_cnt != `BYTE_BITS) begin
            shreg   <= {shreg[6:0], sda_s[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == `BYTE_BITS) begin
            bit_cnt <= 4'h0;
            state   <= ST_ACK;
            if (state == ST_ADDR) begin
              if (shreg[7:1] == {`ADDR_FIXED_HI, addr_lsb} && strap_done) begin
                sda_oe_o  <= 1'b1;
                after_ack <= shreg[0] ? ST_RDATA : ST_REG;
              end else begin
                // master code is never acknowledged by any slave
                if (shreg[7:3] == `HS_MASTER_CODE) begin
                  hs_mode_o <= 1'b1;
                end
                state <= ST_WAIT;
              end
            end else if (state == ST_REG) begin
              reg_ptr   <= shreg;
              ptr_ok    <= ptr_known;
              sda_oe_o  <= ptr_known;
              after_ack <= ptr_known ? ST_WDATA : ST_WAIT;
            end else begin
              // any byte after the data byte is neither stored nor acked
              after_ack <= ST_WAIT;
              if (wdata_ok) begin
                sda_oe_o              <= 1'b1;
                output_voltage_code_o <= shreg[6:0];
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state <= after_ack;
            // the first read bit goes out on the fall that ends the address ack
            if (after_ack == ST_RDATA) begin
              shreg    <= {read_value[6:0], 1'b0};
              sda_oe_o <= ~read_value[7];
              bit_cnt  <= 4'h1;
            end else begin
              sda_oe_o <= 1'b0;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == `BYTE_BITS) begin
              // one byte only; the master's ack bit is left alone
              sda_oe_o <= 1'b0;
              state    <= ST_WAIT;
            end else begin
              sda_oe_o <= ~shreg[7];
              shreg    <= {shreg[6:0], 1'b0};
              bit_cnt  <= bit_cnt + 4'h1;
            end
          end
        end
        default: begin
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ===== tb/i2c_master_model.sv
/* Bus master model: drives scl and pulls sda low.
   Assumes a pull-up resolves sda outside. */
`timescale 1ns/1ps
module i2c_master_model(
  output logic      scl_o,
  output logic      pull_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // scl only toggles inside frames, 400 ns period
  task automatic bit_x(input logic b, output logic s);
    pull_o = !b;
    #100 scl_o = 1'b1;
    #200 s = sda_i;
    scl_o = 1'b0;
    #100;
  endtask
  task automatic start;
    pull_o = 1'b0;
    #100 scl_o = 1'b1;
    #200 pull_o = 1'b1;
    #200 scl_o = 1'b0;
    #100;
  endtask
  task automatic stop;
    pull_o = 1'b1;
    #100 scl_o = 1'b1;
    #200 pull_o = 1'b0;
    #200;
  endtask
  // whole bytes only, msb first; ninth bit released, so a read byte is NAKed
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], s);
      q[i] = s;
    end
    bit_x(1'b1, s);
    ack = !s;
  endtask
endmodule

// ===== tb/vid_telemetry_checker.sv
/* Port checker of the two-wire slave.
   Assumes it is bound to the slave, clock_i at 20 MHz. */
`timescale 1ns/1ps
module vid_telemetry_checker(
  // clock and reset
  input wire logic       clock_i,
  input wire logic       rst_i,
  // two-wire bus
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  // controls
  input wire logic       hs_mode_o,
  input wire logic [6:0] output_voltage_code_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_reset_state: assert property (disable iff (1'b0) rst_i |=> !sda_oe_o && !hs_mode_o
    && output_voltage_code_o == 7'h4B) else $error("reset state wrong");
  a_code_legal: assert property (output_voltage_code_o inside {[7'h19:7'h7F]})
    else $error("illegal voltage code");
  a_code_on_ack: assert property ($changed(output_voltage_code_o) |-> sda_oe_o)
    else $error("code changed without ack");
  a_sda_open_drain: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  // scl is seen three clocks late, so look back that far
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 3))
    else $error("sda moved while scl high");
  a_oe_stands: assert property ($rose(sda_oe_o) |=> sda_oe_o [*6])
    else $error("sda low too short");
  a_oe_bounded: assert property ($rose(sda_oe_o) |-> ##[1:100] !sda_oe_o)
    else $error("sda held too long");
  a_hs_on_nak: assert property ($rose(hs_mode_o) |-> !sda_oe_o)
    else $error("master code acked");
  a_hs_hold: assert property (hs_mode_o && !scl_i |=> hs_mode_o)
    else $error("hs mode left without stop");
  cover property ($rose(hs_mode_o));
  cover property ($changed(output_voltage_code_o));
  cover property ($rose(sda_oe_o));
endmodule
bind vid_telemetry_i2c_slave vid_telemetry_checker vid_telemetry_checker_i(.*);

// ===== tb/tb_vid_telemetry_i2c_slave.sv
/* Self-checking bench of the two-wire slave.
   Assumes the master model and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module tb_vid_telemetry_i2c_slave;
  logic       clock_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [1:0] strap = 2'h0;
  logic [7:0] cur = 8'h00, flt = 8'h00, q, r, d;
  logic [6:0] code, vc;
  logic [2:0] ak, lsb;
  logic       scl, pull, sda_o, sda_oe_o, hs, k;
  wire        sda = !(sda_oe_o | pull);
  int         error_cnt = 0, samples_checked = 0;
  logic [7:0] tbl_d [4] = '{8'h18, 8'h19, 8'h7F, 8'h80};
  logic [7:0] tbl_r [3] = '{8'h01, 8'h03, 8'h14};
  always #25 clock_i = ~clock_i;
  vid_telemetry_i2c_slave vid_telemetry_i2c_slave_i(.clock_i, .rst_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o,
    .address_slew_strap_pin_i(strap), .current_monitor_output_i(cur), .fault_status_i(flt),
    .output_voltage_code_o(code), .hs_mode_o(hs));
  i2c_master_model i2c_master_model_i(.scl_o(scl), .pull_o(pull), .sda_i(sda));
  function automatic logic [2:0] band_lsb(input logic [1:0] b);
    return b == 2'h1 ? 3'h3 : b == 2'h2 ? 3'h5 : 3'h0;
  endfunction
  function automatic logic legal(input logic [7:0] v);
    return v >= 8'h19 && v <= 8'h7F;
  endfunction
  function automatic logic known(input logic [7:0] v);
    return v inside {8'h01, 8'h03, 8'h14};
  endfunction
  function automatic logic [7:0] expect_rd(input logic [7:0] v);
    return v == 8'h01 ? {1'b0, vc} : v == 8'h03 ? cur : v == 8'h14 ? flt : 8'h00;
  endfunction
  task automatic xact(input logic rd, input logic [6:0] a, input logic [7:0] rg, dt, output logic [2:0] f);
    i2c_master_model_i.start;
    i2c_master_model_i.byte_x({a, 1'b0}, q, f[2]);
    i2c_master_model_i.byte_x(rg, q, f[1]);
    if (rd) begin
      i2c_master_model_i.start;
      i2c_master_model_i.byte_x({a, 1'b1}, q, f[0]);
      i2c_master_model_i.byte_x(8'hFF, q, k);
    end else
      i2c_master_model_i.byte_x(dt, q, f[0]);
    i2c_master_model_i.stop;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #3000000;
    error_cnt++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'h1AA2B940));
    strap = 2'($urandom_range(2, 0));
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
    `CHK(code, 7'h4B)
    repeat (20) @(negedge clock_i);
    lsb = band_lsb(strap);
    strap = ~strap;
    vc = 7'h4B;
    xact(1'b0, {4'h8, lsb ^ 3'h2}, 8'h01, 8'h30, ak);
    `CHK({ak, code}, {3'b000, vc})
    i2c_master_model_i.start;
    i2c_master_model_i.byte_x(8'h08, q, k);
    `CHK({k, hs}, 2'b01)
    i2c_master_model_i.stop;
    `CHK(hs, 1'b0)
    for (int n = 0; n < 16; n++) begin
      d = n < 4 ? tbl_d[n] : 8'($urandom);
      r = n % 4 == 3 ? 8'($urandom) : tbl_r[n % 4];
      cur = 8'($urandom);
      flt = 8'($urandom);
      xact(1'b0, {4'h8, lsb}, 8'h01, d, ak);
      if (legal(d)) vc = d[6:0];
      `CHK({ak, code}, {2'b11, legal(d), vc})
      xact(1'b0, {4'h8, lsb}, r, d, ak);
      if (r == 8'h01 && legal(d)) vc = d[6:0];
      `CHK({ak, code}, {1'b1, known(r), r == 8'h01 && legal(d), vc})
      xact(1'b1, {4'h8, lsb}, r, d, ak);
      `CHK(ak, {1'b1, known(r), 1'b1})
      `CHK(q, expect_rd(r))
    end
    wrap_up;
  end
endmodule
